// File: xbus_decode_pkg.sv
// constants for the x-bus chip select decode block
// assumes a 32-bit memory/io cycle address supplied per decoded cycle
package xbus_decode_pkg;
  // register port offsets (byte addresses, one word apart except ctrl_addr, two bytes below status_addr)
  localparam logic [7:0]  ctrl_addr      = 8'h4e;
  localparam logic [7:0]  status_addr    = 8'h50;
  localparam logic [7:0]  mask_addr      = 8'h54;
  localparam logic [7:0]  intc_base_addr = 8'h58;
  // control register layout
  localparam logic [15:0] ctrl_reset     = 16'h0003;
  localparam logic [15:0] ctrl_wmask     = 16'h01f7;
  localparam int          b_rtc          = 0;
  localparam int          b_kbd          = 1;
  localparam int          b_wr_en        = 2;
  localparam int          b_mouse        = 4;
  localparam int          b_fpu          = 5;
  localparam int          b_low_bios     = 6;
  localparam int          b_ext_bios     = 7;
  localparam int          b_intc         = 8;
  // decode windows
  localparam logic [31:0] intc_base_reset = 32'hfec0_0000;
  localparam logic [31:0] ext_bios_lo     = 32'hfff8_0000;
  localparam logic [31:0] ext_bios_hi     = 32'hfffd_ffff;
  localparam logic [31:0] low_bios_lo     = 32'h000e_0000;
  localparam logic [31:0] low_bios_hi     = 32'h000e_ffff;
  localparam logic [31:0] alias_bios_lo   = 32'hfffe_0000;
  localparam logic [31:0] alias_bios_hi   = 32'hfffe_ffff;
  localparam logic [15:0] kbd_port0       = 16'h0060;
  localparam logic [15:0] kbd_port1       = 16'h0064;
  localparam logic [15:0] rtc_port_lo     = 16'h0070;
  localparam logic [15:0] rtc_port_hi     = 16'h0077;
  localparam logic [3:0]  la_top_ones     = 4'hf;
  // status bits
  localparam int          st_fpu         = 0;
  localparam int          st_ignored     = 1;
  localparam int          st_width       = 2;
endpackage

// File: xbus_chip_select_decode.sv
// x-bus chip select decode with its control register
// assumes one decoded bus cycle per cycle_valid pulse, synchronous to clk
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module xbus_chip_select_decode
  import xbus_decode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        cycle_valid,
  input  wire logic [31:0] cycle_addr,
  input  wire logic        cycle_is_io,
  input  wire logic        cycle_is_write,
  input  wire logic        cycle_from_isa,
  output logic             intc_chip_select_n,
  output logic             boot_rom_select_n,
  output logic             kbd_ctrl_select_n,
  output logic             clock_chip_select_n,
  output logic             clock_addr_latch_en,
  output logic             xbus_xcvr_oe_n,
  output logic             isa_forward,
  output logic             la_force_ones,
  input  wire logic        fpu_error_in_n,
  output logic             ignore_num_err_out_n,
  output logic             irq13_out,
  output logic             irq12_pointer_option,
  input  wire logic        shared_req_in_n,
  input  wire logic        bus_reset_req_n,
  input  wire logic        intc_acknowledge_req_n,
  output logic             shared_ack_out_n,
  output logic             test_input_n,
  output logic             intc_request_n,
  output logic             irq_out
);

  logic [15:0]         xbus_select_control;
  logic [31:0]         intc_base;
  logic [st_width-1:0] status;
  logic [st_width-1:0] mask;
  logic                fpu_err_d;

  // register port decode
  wire                sel_ctrl   = reg_addr == ctrl_addr;
  wire                sel_status = reg_addr == status_addr;
  wire                sel_mask   = reg_addr == mask_addr;
  wire                sel_base   = reg_addr == intc_base_addr;
  wire                wr_ctrl    = reg_write && sel_ctrl;
  wire                wr_mask    = reg_write && sel_mask;
  wire                wr_base    = reg_write && sel_base;
  wire                rd_status  = reg_read && sel_status;
  wire [15:0]         next_ctrl  = reg_wdata[15:0] & ctrl_wmask;

  wire en_rtc  = xbus_select_control[b_rtc];
  wire en_kbd  = xbus_select_control[b_kbd];
  wire en_wr   = xbus_select_control[b_wr_en];
  wire en_fpu  = xbus_select_control[b_fpu];
  wire en_low  = xbus_select_control[b_low_bios];
  wire en_ext  = xbus_select_control[b_ext_bios];
  wire en_intc = xbus_select_control[b_intc];

  // address windows
  wire        mem        = cycle_valid && !cycle_is_io;
  wire        io         = cycle_valid && cycle_is_io;
  wire [15:0] port       = cycle_addr[15:0];
  wire        in_intc    = mem && (cycle_addr[31:1] == intc_base[31:1]);
  wire        in_ext     = mem && !cycle_from_isa
                           && cycle_addr >= ext_bios_lo && cycle_addr <= ext_bios_hi;
  wire        in_low     = mem && cycle_addr >= low_bios_lo && cycle_addr <= low_bios_hi;
  wire        in_alias   = mem && cycle_addr >= alias_bios_lo
                           && cycle_addr <= alias_bios_hi;
  wire        in_kbd     = io && (port == kbd_port0 || port == kbd_port1);
  wire        in_rtc     = io && port >= rtc_port_lo && port <= rtc_port_hi;

  // decode, each gated by its enable
  wire hit_intc  = in_intc && en_intc && !cycle_from_isa;
  wire hit_ext   = in_ext && en_ext;
  wire hit_low   = (in_low || in_alias) && en_low;
  wire bios_hit  = (hit_ext || hit_low) && (en_wr || !cycle_is_write);
  wire hit_kbd   = in_kbd && en_kbd;
  wire hit_rtc   = in_rtc && en_rtc;
  wire any_hit   = hit_intc || bios_hit || hit_kbd || hit_rtc;
  wire top_fwd   = hit_ext || (hit_low && in_alias);
  wire ignored   = in_intc && !en_intc && !cycle_from_isa;

  // coprocessor error path
  wire fpu_err    = en_fpu && !fpu_error_in_n;
  wire fpu_rise   = fpu_err && !fpu_err_d;
  wire [st_width-1:0] events = {ignored, fpu_rise};

  wire [31:0] rd_mux = sel_ctrl   ? {16'h0000, xbus_select_control} :
                       sel_status ? {30'h0, status} :
                       sel_mask   ? {30'h0, mask} :
                       sel_base   ? intc_base : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      xbus_select_control <= ctrl_reset;
      intc_base           <= intc_base_reset;
      mask                <= '0;
      fpu_err_d           <= 1'b0;
      reg_rdata           <= '0;
    end else begin
      if (wr_ctrl) xbus_select_control <= next_ctrl;
      if (wr_base) intc_base <= reg_wdata;
      if (wr_mask) mask <= reg_wdata[st_width-1:0];
      fpu_err_d <= fpu_err;
      reg_rdata <= reg_read ? rd_mux : 32'h0000_0000;
    end
  end

  // sticky status: set wins over read clear
  genvar gi;
  generate
    for (gi = 0; gi < st_width; gi++) begin : g_status
      always_ff @(posedge clk) begin
        if (srst) status[gi] <= 1'b0;
        else if (events[gi]) status[gi] <= 1'b1;
        else if (rd_status) status[gi] <= 1'b0;
      end
    end
  endgenerate

  // registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      intc_chip_select_n   <= 1'b1;
      boot_rom_select_n    <= 1'b1;
      kbd_ctrl_select_n    <= 1'b1;
      clock_chip_select_n  <= 1'b1;
      clock_addr_latch_en  <= 1'b0;
      xbus_xcvr_oe_n       <= 1'b1;
      isa_forward          <= 1'b0;
      la_force_ones        <= 1'b0;
      ignore_num_err_out_n <= 1'b1;
      irq13_out            <= 1'b0;
      irq12_pointer_option <= 1'b0;
      shared_ack_out_n     <= 1'b1;
      test_input_n         <= 1'b1;
      intc_request_n       <= 1'b1;
      irq_out              <= 1'b0;
    end else begin
      intc_chip_select_n   <= !hit_intc;
      boot_rom_select_n    <= !bios_hit;
      kbd_ctrl_select_n    <= !hit_kbd;
      clock_chip_select_n  <= !hit_rtc;
      clock_addr_latch_en  <= hit_rtc;
      xbus_xcvr_oe_n       <= !any_hit;
      isa_forward          <= hit_intc || hit_ext || hit_low;
      la_force_ones        <= top_fwd;
      ignore_num_err_out_n <= !fpu_err;
      irq13_out            <= fpu_err;
      irq12_pointer_option <= xbus_select_control[b_mouse];
      shared_ack_out_n     <= en_intc ? intc_acknowledge_req_n
                                      : bus_reset_req_n;
      test_input_n         <= en_intc ? 1'b1 : shared_req_in_n;
      intc_request_n       <= en_intc ? shared_req_in_n : 1'b1;
      irq_out              <= |(status & mask);
    end
  end

endmodule

// File: xbus_decode_chk.sv
// port checker for the x-bus chip select decode
// assumes binding onto xbus_chip_select_decode, one clock, srst high
`timescale 1ns/1ps
module xbus_decode_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cycle_valid,
  input wire logic [31:0] cycle_addr,
  input wire logic        cycle_is_io,
  input wire logic        cycle_from_isa,
  input wire logic        intc_chip_select_n,
  input wire logic        boot_rom_select_n,
  input wire logic        kbd_ctrl_select_n,
  input wire logic        clock_chip_select_n,
  input wire logic        clock_addr_latch_en,
  input wire logic        xbus_xcvr_oe_n,
  input wire logic        isa_forward,
  input wire logic        la_force_ones
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence isa_cyc;
    cycle_valid && cycle_from_isa;
  endsequence
  a_isa_no_intc: assert property (isa_cyc |=> intc_chip_select_n)
    else $error("intc select on isa cycle");
  a_isa_no_ext: assert property (isa_cyc
    ##0 cycle_addr inside {[32'hfff80000:32'hfffdffff]} |=> boot_rom_select_n)
    else $error("extended rom select on isa cycle");
  a_mem_no_io: assert property (cycle_valid && !cycle_is_io
    |=> kbd_ctrl_select_n && clock_chip_select_n) else $error("io select on memory cycle");
  a_io_no_mem: assert property (cycle_valid && cycle_is_io
    |=> boot_rom_select_n && intc_chip_select_n) else $error("memory select on io cycle");
  a_idle_quiet: assert property (!cycle_valid |=> xbus_xcvr_oe_n && !isa_forward)
    else $error("activity without a cycle");
  a_oe_with_sel: assert property (!(boot_rom_select_n && kbd_ctrl_select_n
    && clock_chip_select_n && intc_chip_select_n) |-> !xbus_xcvr_oe_n) else $error("oe missing");
  a_ale_with_cs: assert property (clock_addr_latch_en != clock_chip_select_n)
    else $error("latch enable apart from clock select");
  a_la_fwd: assert property (la_force_ones |-> isa_forward)
    else $error("upper address forced without forwarding");
endmodule
bind xbus_chip_select_decode xbus_decode_chk chk_u (.*);

// File: xbus_far_side.sv
// far-side peripherals: coprocessor error line and shared request pin
// assumes level commands from the testbench on the same clock
`timescale 1ns/1ps
module xbus_far_side (
  input  wire logic clk,
  input  wire logic err_cmd,
  input  wire logic req_cmd,
  output logic      fpu_error_in_n = 1'b1,
  output logic      shared_req_in_n = 1'b1
);
  // no isa add-in memory answers in the aliased rom range
  always_ff @(posedge clk) begin
    fpu_error_in_n  <= !err_cmd;
    shared_req_in_n <= !req_cmd;
  end
endmodule

// File: tb_xbus_chip_select_decode.sv
// testbench for the x-bus chip select decode
// assumes the far-side model drives the error and shared request pins
`timescale 1ns/1ps
module tb_xbus_chip_select_decode;
  import xbus_decode_pkg::*;
  logic        clk = '0, srst = '1, reg_write = '0, reg_read = '0, cycle_valid = '0;
  logic        cycle_is_io = '0, cycle_is_write = '0, cycle_from_isa = '0, err_cmd = '0;
  logic        bus_reset_req_n = '1, intc_acknowledge_req_n = '1, req_cmd = '0;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, cycle_addr = '0, reg_rdata;
  logic        intc_chip_select_n, boot_rom_select_n, kbd_ctrl_select_n, clock_chip_select_n;
  logic        clock_addr_latch_en, xbus_xcvr_oe_n, isa_forward, la_force_ones, irq_out;
  logic        fpu_error_in_n, ignore_num_err_out_n, irq13_out, irq12_pointer_option;
  logic        shared_req_in_n, shared_ack_out_n, test_input_n, intc_request_n;
  int          n_errors = 0, num_checks = 0;
  xbus_chip_select_decode dut_u (.*);
  xbus_far_side far_u (.*);
  initial forever #5 clk = ~clk;
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // expected: intc, rom, kbd, clock selects, latch, oe, forward, upper ones
  task automatic cyc(input logic [31:0] a, input logic io, w, isa, input logic [7:0] e);
    @(posedge clk);
    cycle_valid    <= 1'b1;
    cycle_addr     <= a;
    cycle_is_io    <= io;
    cycle_is_write <= w;
    cycle_from_isa <= isa;
    @(posedge clk);
    cycle_valid <= 1'b0;
    #1 chk({intc_chip_select_n, boot_rom_select_n, kbd_ctrl_select_n, clock_chip_select_n,
            clock_addr_latch_en, xbus_xcvr_oe_n, isa_forward, la_force_ones}, {24'h0, e});
  endtask
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(ctrl_addr, 32'h0000_0003);
    wr(ctrl_addr, 32'hffff_ffff);
    rd(ctrl_addr, 32'h0000_01f7);
    rd(8'h7c, 32'h0);
    cyc(32'hfec0_0001, 0, 0, 0, 8'h72);
    cyc(32'hfec0_0000, 0, 0, 1, 8'hf4);
    cyc(32'hfffd_ffff, 0, 0, 0, 8'hb3);
    cyc(32'hfff8_0000, 0, 0, 1, 8'hf4);
    cyc(32'h000e_0000, 0, 0, 1, 8'hb2);
    cyc(32'hfffe_ffff, 0, 1, 0, 8'hb3);
    cyc(32'h0000_0064, 1, 0, 0, 8'hd0);
    cyc(32'h0000_0061, 1, 0, 0, 8'hf4);
    cyc(32'h0000_0077, 1, 1, 0, 8'he8);
    cyc(32'h0000_0078, 1, 0, 0, 8'hf4);
    wr(intc_base_addr, 32'h1000_0000);
    cyc(32'h1000_0001, 0, 0, 0, 8'h72);
    cyc(32'h1000_0002, 0, 0, 0, 8'hf4);
    wr(ctrl_addr, 32'h0000_00c0);
    cyc(32'h000e_0000, 0, 1, 0, 8'hf6);
    wr(ctrl_addr, 32'h0);
    wr(mask_addr, 32'h3);
    cyc(32'h1000_0000, 0, 0, 0, 8'hf4);
    cyc(32'hfff8_0000, 0, 0, 0, 8'hf4);
    cyc(32'hfffe_0000, 0, 0, 0, 8'hf4);
    cyc(32'h0000_0060, 1, 0, 0, 8'hf4);
    cyc(32'h0000_0070, 1, 0, 0, 8'hf4);
    chk(irq_out, 1'b1);
    rd(status_addr, 32'h2);
    wr(ctrl_addr, 32'h0000_0030);
    err_cmd         <= 1'b1;
    req_cmd         <= 1'b1;
    bus_reset_req_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({irq13_out, ignore_num_err_out_n, irq12_pointer_option, irq_out}, 4'b1011);
    chk({test_input_n, intc_request_n, shared_ack_out_n}, 3'b010);
    wr(mask_addr, 32'h0);
    @(posedge clk);
    #1 chk(irq_out, 1'b0);
    rd(status_addr, 32'h1);
    wr(ctrl_addr, 32'h0000_0100);
    intc_acknowledge_req_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({test_input_n, intc_request_n, shared_ack_out_n, irq13_out}, 4'b1000);
    chk(irq12_pointer_option, 1'b0);
    final_report;
  end
endmodule
